// ### image_resizer.sv
// polyphase image resizer: memory to memory, horizontal then vertical pass
// assumes a byte-wide memory master port with read data valid alongside ack, one clock
//
// Summary of operation
// - scale is 256/N with step N accepted from 64 to 1024.
// - horizontal and vertical steps programmed separately, same resampler.
// - 32 programmable coefficients per direction.
// - up to 1/2x reduction, coefficients are 4 taps by 8 phases.
// - below 1/2x, coefficients are 7 taps by 4 phases.
// - chroma select 0 filters chroma like luma, 1 uses bilinear in the horizontal pass of packed input.
// - packed 16-bit or planar 8-bit input, same format on output.
// - packed input resized luma and chroma together in one job.
// - pixel order picks luma or chroma first, ignored when planar.
// - source fetched from memory, result written back to memory.
// - horizontal pass first, then vertical, edge stage between them is a bypass.
`timescale 1ns/1ps
`default_nettype none
`include "resizer_defs.svh"

module image_resizer
    import resizer_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // register port
    input wire reg_req_t reg_req,
    output logic [31:0] reg_rdata,
    // memory master
    output mem_cmd_t mem_cmd,
    input wire mem_rsp_t mem_rsp,
    // interrupt
    output logic irq
);

    core_t s_r;
    core_t s_nxt;

    // datapath terms derived from the current output position
    logic is_chroma;
    logic bil;
    logic hred;
    logic vred;
    logic [2:0] htaps;
    logic [2:0] vtaps;
    logic [11:0] o_luma;
    logic [23:0] ph;
    logic [23:0] pv;
    logic [11:0] col;
    logic [11:0] col_lim;
    logic [11:0] row;
    logic [13:0] boff;
    logic [31:0] rd_addr;
    logic [31:0] wr_addr;
    logic [4:0] hidx;
    logic [4:0] vidx;
    logic signed [9:0] hcoef;
    logic signed [9:0] vcoef;
    logic signed [21:0] hprod;
    logic signed [21:0] hnew;
    logic signed [13:0] hval;
    logic signed [27:0] vnew;
    logic signed [19:0] vres;
    logic [7:0] pix;
    logic [11:0] ox_last;
    logic hstep_ok;
    logic vstep_ok;
    logic size_ok;
    logic step_ok;
    logic [1:0] ev;

    // packed rows carry two bytes per pixel, planar one
    // byte lane of luma follows the pixel order in packed mode only
    assign is_chroma = !s_r.mode.planar && (s_r.ox[0] != s_r.mode.cfirst);
    // bilinear only ever applies to chroma samples
    assign bil = is_chroma && s_r.mode.bilin;
    // step of 512 or less keeps the 4-tap 8-phase bank
    // larger steps switch to the 7-tap 4-phase bank
    // the step register carries the software-derived N directly
    assign hred = s_r.sth > `RSZ_STEP_HALF;
    assign vred = s_r.stv > `RSZ_STEP_HALF;
    assign htaps = bil ? 3'd2 : (hred ? 3'd7 : 3'd4);
    assign vtaps = vred ? 3'd7 : 3'd4;
    // chroma pairs share the position of the even luma pixel
    assign o_luma = s_r.mode.planar ? s_r.ox
                  : (is_chroma ? {s_r.ox[11:2], 2'b00} >> 1 : s_r.ox >> 1);

    // position advances by the step in 1/256 input pixels
    // each direction walks its own step and start phase
    always_comb begin
        logic [23:0] hbase;
        logic [23:0] hpos;
        logic [23:0] vbase;
        hbase = hred ? {15'd0, s_r.sph, 6'd0} : {16'd0, s_r.sph, 5'd0};
        hpos = hbase + 24'(o_luma * s_r.sth);
        // chroma runs at half the luma sample rate
        ph = is_chroma ? (hpos >> 1) : hpos;
        vbase = vred ? {15'd0, s_r.spv, 6'd0} : {16'd0, s_r.spv, 5'd0};
        pv = vbase + 24'(s_r.oy * s_r.stv);
    end

    // taps stay inside the programmed input when sized correctly
    // clamping only guards against an undersized input setting
    always_comb begin
        logic [11:0] c;
        logic [11:0] r;
        c = ph[19:8] + {9'd0, s_r.ht};
        r = pv[19:8] + {9'd0, s_r.vt};
        col_lim = is_chroma ? {2'b00, s_r.iw[10:1]} : {1'b0, s_r.iw};
        col = (c >= col_lim && col_lim != 12'd0) ? col_lim - 12'd1 : c;
        row = (r >= {1'b0, s_r.ih} && s_r.ih != 11'd0) ? {1'b0, s_r.ih} - 12'd1 : r;
    end

    // planar jobs see one component, so a byte is a sample
    always_comb begin
        if (s_r.mode.planar) begin
            boff = {2'b00, col};
        end else if (is_chroma) begin
            boff = {col, 2'b00} + {12'd0, s_r.ox[1], !s_r.mode.cfirst};
        end else begin
            boff = {1'b0, col, 1'b0} + {13'd0, s_r.mode.cfirst};
        end
    end

    // source and destination are both plain memory images
    assign rd_addr = s_r.src + 32'(row * s_r.sp) + {18'd0, boff};
    assign wr_addr = s_r.dst + 32'(s_r.oy * s_r.dp) + {20'd0, s_r.ox};
    // no alignment check on bases or pitches; software keeps them legal
    assign ox_last = s_r.mode.planar ? {1'b0, s_r.output_width} - 12'd1
                   : {s_r.output_width, 1'b0} - 12'd1;

    // one 32-entry bank per direction, indexed by phase and tap
    assign hidx = hred ? {ph[7:6], s_r.ht} : {ph[7:5], s_r.ht[1:0]};
    assign vidx = vred ? {pv[7:6], s_r.vt} : {pv[7:5], s_r.vt[1:0]};
    // bilinear weights come from the fractional position
    assign hcoef = bil ? (s_r.ht == 3'd0 ? $signed(`RSZ_UNITY - {2'b00, ph[7:0]})
                                         : $signed({2'b00, ph[7:0]}))
                       : $signed(s_r.ch[hidx]);
    assign vcoef = $signed(s_r.cv[vidx]);
    assign hprod = 22'(hcoef * $signed({1'b0, mem_rsp.rdata}));
    assign hnew = s_r.hsum + hprod;
    // horizontal result feeds the vertical stage; edge stage is a bypass
    assign hval = 14'(hnew >>> 8);
    assign vnew = s_r.vacc + 28'(hval * vcoef);
    assign vres = 20'(s_r.vacc >>> 8);
    assign pix = vres[19] ? 8'h00 : (vres > $signed(`RSZ_PIX_MAX) ? 8'hFF : vres[7:0]);

    // only steps 64..1024 are accepted for a job
    // zero output sizes would wrap the end-of-line compare, so they are refused too
    assign hstep_ok = s_r.sth >= `RSZ_STEP_MIN && s_r.sth <= `RSZ_STEP_MAX;
    assign vstep_ok = s_r.stv >= `RSZ_STEP_MIN && s_r.stv <= `RSZ_STEP_MAX;
    assign size_ok = s_r.output_width != 11'd0 && s_r.output_height != 11'd0;
    assign step_ok = hstep_ok && vstep_ok && size_ok;

    always_comb begin
        s_nxt = s_r;
        ev = 2'b00;
        s_nxt.rdata = 32'h0000_0000;

        // register writes
        // coefficient pages stay writable mid-job; a rewrite then mixes banks
        if (reg_req.wr) begin
            if (reg_req.addr[7:5] == `RSZ_PAGE_COEF_H) begin
                s_nxt.ch[reg_req.addr[4:0]] = reg_req.wdata[9:0];
            end else if (reg_req.addr[7:5] == `RSZ_PAGE_COEF_V) begin
                s_nxt.cv[reg_req.addr[4:0]] = reg_req.wdata[9:0];
            end else begin
                case (reg_req.addr)
                    `RSZ_OFF_CTRL: begin
                        // mode is frozen while a job runs
                        if (!s_r.busy) begin
                            s_nxt.mode.planar = reg_req.wdata[`RSZ_CTRL_PLANAR];
                            s_nxt.mode.cfirst = reg_req.wdata[`RSZ_CTRL_CFIRST];
                            s_nxt.mode.bilin = reg_req.wdata[`RSZ_CTRL_BILIN];
                        end
                        if (reg_req.wdata[`RSZ_CTRL_START]) begin
                            if (s_r.busy || !step_ok) begin
                                ev[`RSZ_INT_ERR] = 1'b1;
                            end else begin
                                s_nxt.busy = 1'b1;
                                s_nxt.st = ST_ADDR;
                                s_nxt.ox = 12'd0;
                                s_nxt.oy = 11'd0;
                                s_nxt.vt = 3'd0;
                                s_nxt.ht = 3'd0;
                                s_nxt.hsum = '0;
                                s_nxt.vacc = '0;
                            end
                        end
                    end
                    `RSZ_OFF_INT_MASK: begin
                        s_nxt.imask = reg_req.wdata[1:0];
                    end
                    `RSZ_OFF_IN_SIZE: begin
                        s_nxt.iw = reg_req.wdata[10:0];
                        s_nxt.ih = reg_req.wdata[26:16];
                    end
                    `RSZ_OFF_OUT_SIZE: begin
                        s_nxt.output_width = reg_req.wdata[10:0];
                        s_nxt.output_height = reg_req.wdata[26:16];
                    end
                    `RSZ_OFF_STEP: begin
                        s_nxt.sth = reg_req.wdata[10:0];
                        s_nxt.stv = reg_req.wdata[26:16];
                    end
                    `RSZ_OFF_PHASE: begin
                        s_nxt.sph = reg_req.wdata[2:0];
                        s_nxt.spv = reg_req.wdata[10:8];
                    end
                    `RSZ_OFF_SRC_ADDR: begin
                        s_nxt.src = reg_req.wdata;
                    end
                    `RSZ_OFF_DST_ADDR: begin
                        s_nxt.dst = reg_req.wdata;
                    end
                    `RSZ_OFF_PITCH: begin
                        s_nxt.sp = reg_req.wdata[15:0];
                        s_nxt.dp = reg_req.wdata[31:16];
                    end
                    default: ;
                endcase
            end
        end

        // register reads, answered in the next cycle only
        if (reg_req.rd) begin
            if (reg_req.addr[7:5] == `RSZ_PAGE_COEF_H) begin
                s_nxt.rdata = {22'd0, s_r.ch[reg_req.addr[4:0]]};
            end else if (reg_req.addr[7:5] == `RSZ_PAGE_COEF_V) begin
                s_nxt.rdata = {22'd0, s_r.cv[reg_req.addr[4:0]]};
            end else begin
                case (reg_req.addr)
                    `RSZ_OFF_CTRL: s_nxt.rdata = {28'd0, s_r.mode.bilin, s_r.mode.cfirst,
                                                  s_r.mode.planar, 1'b0};
                    `RSZ_OFF_STATUS: s_nxt.rdata = {31'd0, s_r.busy};
                    `RSZ_OFF_INT_STATUS: s_nxt.rdata = {30'd0, s_r.ists};
                    `RSZ_OFF_INT_MASK: s_nxt.rdata = {30'd0, s_r.imask};
                    `RSZ_OFF_IN_SIZE: s_nxt.rdata = {5'd0, s_r.ih, 5'd0, s_r.iw};
                    `RSZ_OFF_OUT_SIZE: s_nxt.rdata = {5'd0, s_r.output_height,
                                                      5'd0, s_r.output_width};
                    `RSZ_OFF_STEP: s_nxt.rdata = {5'd0, s_r.stv, 5'd0, s_r.sth};
                    `RSZ_OFF_PHASE: s_nxt.rdata = {21'd0, s_r.spv, 5'd0, s_r.sph};
                    `RSZ_OFF_SRC_ADDR: s_nxt.rdata = s_r.src;
                    `RSZ_OFF_DST_ADDR: s_nxt.rdata = s_r.dst;
                    `RSZ_OFF_PITCH: s_nxt.rdata = {s_r.dp, s_r.sp};
                    default: s_nxt.rdata = 32'h0000_0000;
                endcase
            end
        end

        // job sequencer: one fetch per tap, taps_h x taps_v per output byte
        // no line memory: every tap is refetched, trading bandwidth for area
        case (s_r.st)
            ST_IDLE: begin
                s_nxt.mem.req = 1'b0;
                s_nxt.mem.we = 1'b0;
            end
            ST_ADDR: begin
                s_nxt.mem.req = 1'b1;
                s_nxt.mem.we = 1'b0;
                s_nxt.mem.addr = rd_addr;
                s_nxt.st = ST_FETCH;
            end
            ST_FETCH: begin
                if (mem_rsp.ack) begin
                    s_nxt.mem.req = 1'b0;
                    s_nxt.st = ST_ADDR;
                    if (s_r.ht == htaps - 3'd1) begin
                        // a finished horizontal sum enters the vertical one
                        s_nxt.ht = 3'd0;
                        s_nxt.hsum = '0;
                        s_nxt.vacc = vnew;
                        if (s_r.vt == vtaps - 3'd1) begin
                            s_nxt.vt = 3'd0;
                            s_nxt.st = ST_WRITE;
                        end else begin
                            s_nxt.vt = s_r.vt + 3'd1;
                        end
                    end else begin
                        s_nxt.ht = s_r.ht + 3'd1;
                        s_nxt.hsum = hnew;
                    end
                end
            end
            ST_WRITE: begin
                // each result byte goes straight back to memory
                s_nxt.mem.req = 1'b1;
                s_nxt.mem.we = 1'b1;
                s_nxt.mem.addr = wr_addr;
                s_nxt.mem.wdata = pix;
                if (s_r.mem.req && s_r.mem.we && mem_rsp.ack) begin
                    s_nxt.mem.req = 1'b0;
                    s_nxt.mem.we = 1'b0;
                    s_nxt.vacc = '0;
                    s_nxt.st = ST_ADDR;
                    if (s_r.ox == ox_last) begin
                        s_nxt.ox = 12'd0;
                        s_nxt.oy = s_r.oy + 11'd1;
                        if (s_r.oy == s_r.output_height - 11'd1) begin
                            // done once the last line is written
                            s_nxt.busy = 1'b0;
                            s_nxt.st = ST_IDLE;
                            ev[`RSZ_INT_DONE] = 1'b1;
                        end
                    end else begin
                        s_nxt.ox = s_r.ox + 12'd1;
                    end
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase

        // write-one-to-clear; a new event wins over a clear in the same cycle
        if (reg_req.wr && reg_req.addr == `RSZ_OFF_INT_STATUS) begin
            s_nxt.ists = s_r.ists & ~reg_req.wdata[1:0];
        end
        s_nxt.ists = s_nxt.ists | ev;
    end

    // synchronous reset clears the whole state record in one go
    always_ff @(posedge clock) begin
        if (!resetn) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rdata;
    assign mem_cmd = s_r.mem;
    // level output, drops as soon as the flag is cleared or masked
    assign irq = |(s_r.ists & s_r.imask);

endmodule : image_resizer
`default_nettype wire

// ### image_resizer_asserts.sv
// port checker for the resizer: register port, memory master, interrupt
// sees only top-level ports; bound below the module
`timescale 1ns/1ps
`default_nettype none
`include "resizer_defs.svh"

module image_resizer_asserts
    import resizer_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // register port
    input wire reg_req_t reg_req,
    input wire logic [31:0] reg_rdata,
    // memory master and interrupt
    input wire mem_cmd_t mem_cmd,
    input wire mem_rsp_t mem_rsp,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    // shadow of the mask, so irq can be judged without internals
    logic [1:0] mask_r;
    always_ff @(posedge clock) begin
        if (!resetn) begin
            mask_r <= 2'h0;
        end else if (reg_req.wr && reg_req.addr == `RSZ_OFF_INT_MASK) begin
            mask_r <= reg_req.wdata[1:0];
        end
    end

    a_rdata_idle: assert property (!reg_req.rd |=> reg_rdata == 32'h0) // quiet read port
        else $error("read data not zero outside read answer");
    a_req_hold: assert property ( // held request
        mem_cmd.req && !mem_rsp.ack |=> mem_cmd.req && $stable(mem_cmd))
        else $error("memory request changed before ack");
    a_req_drop: assert property ( // request release
        mem_cmd.req && mem_rsp.ack |=> !mem_cmd.req)
        else $error("memory request not dropped after ack");
    a_start_reads0: assert property ( // start bit
        reg_req.rd && reg_req.addr == `RSZ_OFF_CTRL |=> !reg_rdata[0])
        else $error("start bit read back as one");
    a_unmapped_zero: assert property ( // unmapped space
        reg_req.rd && reg_req.addr inside {[8'h0B:8'h1F]} |=> reg_rdata == 32'h0)
        else $error("unmapped offset read nonzero");
    a_coef_back: assert property ( // coefficient store
        (reg_req.wr && reg_req.addr[7:5] inside {3'h1, 3'h2}) ##2
        (reg_req.rd && reg_req.addr == $past(reg_req.addr, 2))
        |=> reg_rdata[9:0] == $past(reg_req.wdata[9:0], 3))
        else $error("coefficient read back differs");
    a_step_back: assert property ( // two steps
        (reg_req.wr && reg_req.addr == `RSZ_OFF_STEP) ##2
        (reg_req.rd && reg_req.addr == `RSZ_OFF_STEP)
        |=> (reg_rdata & 32'h07FF07FF) == ($past(reg_req.wdata, 3) & 32'h07FF07FF))
        else $error("step read back differs");
    a_irq_masked: assert property (mask_r == 2'h0 |-> !irq) // masked interrupt
        else $error("interrupt raised with all sources masked");

    c_write_ack: cover property (mem_cmd.req && mem_cmd.we && mem_rsp.ack);
    c_read_ack: cover property (mem_cmd.req && !mem_cmd.we && mem_rsp.ack);
    c_irq: cover property ($rose(irq));
endmodule : image_resizer_asserts

bind image_resizer image_resizer_asserts chk_i (.clock(clock), .resetn(resetn),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .mem_cmd(mem_cmd), .mem_rsp(mem_rsp), .irq(irq));
`default_nettype wire

// ### image_resizer_tb.sv
// self-checking bench for the resizer: register tasks, memory partner
// assumes the port checker is bound from its own file
`timescale 1ns/1ps
`default_nettype none
`include "resizer_defs.svh"

module image_resizer_tb
    import resizer_pkg::*;
;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic slow = 1'b0;
    reg_req_t reg_req = '0;
    logic [31:0] reg_rdata;
    mem_cmd_t mem_cmd;
    mem_rsp_t mem_rsp;
    logic irq;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int w0;
    int r0;
    int i;
    int j;
    logic [31:0] d;

    image_resizer dut (.clock(clock), .resetn(resetn), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .mem_cmd(mem_cmd), .mem_rsp(mem_rsp), .irq(irq));
    resizer_mem_model mem_i (.clock(clock), .resetn(resetn), .mem_cmd(mem_cmd),
        .mem_rsp(mem_rsp), .slow(slow));

    initial begin
        forever #25 clock = ~clock;
    end

    task automatic stop_test;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // address-dependent pattern, differs between source and destination areas
    function automatic logic [7:0] pat(input int a);
        return 8'(a ^ (a >> 4) ^ 8'h35);
    endfunction : pat

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clock);
        reg_req <= '0;
        @(posedge clock);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clock);
        reg_req <= '0;
        @(posedge clock);
        v = reg_rdata;
    endtask : rd

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(v, exp);
    endtask : rd_chk

    task automatic outchk(input int dofs, input int sofs);
        chk({24'h0, mem_i.mem[32'h400 + dofs]}, {24'h0, pat(32'h100 + sofs)});
    endtask : outchk

    task automatic cfg(input logic [10:0] iw, ih, width_out, height_out, sh, sv);
        wr(`RSZ_OFF_IN_SIZE, {5'h00, ih, 5'h00, iw});
        wr(`RSZ_OFF_OUT_SIZE, {5'h00, height_out, 5'h00, width_out});
        wr(`RSZ_OFF_PHASE, 32'h0);
        wr(`RSZ_OFF_SRC_ADDR, 32'h100);
        wr(`RSZ_OFF_DST_ADDR, 32'h400);
        wr(`RSZ_OFF_PITCH, 32'h00100010);
        wr(`RSZ_OFF_STEP, {5'h00, sv, 5'h00, sh});
        rd_chk(`RSZ_OFF_STEP, {5'h00, sv, 5'h00, sh}); // separate steps
    endtask : cfg

    // poll busy under a bound; stale output area is scrubbed first
    task automatic run(input logic [31:0] ctrl);
        int k;
        for (k = 32'h400; k < 32'h500; k++) mem_i.mem[k] = 8'hEE;
        w0 = mem_i.n_wr;
        r0 = mem_i.n_rd;
        wr(`RSZ_OFF_CTRL, ctrl | 32'h1);
        d = 32'h1;
        for (k = 0; k < 3000 && d[0] !== 1'b0; k++) rd(`RSZ_OFF_STATUS, d);
        chk(d, 32'h0); // job ends
    endtask : run

    initial begin
        for (i = 0; i < 4096; i++) mem_i.mem[i] = pat(i);
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        rd_chk(`RSZ_OFF_INT_STATUS, 32'h0); // clean after reset
        wr(`RSZ_OFF_INT_MASK, 32'h3);
        wr(8'h1F, 32'hFFFFFFFF);
        rd_chk(8'h1F, 32'h0); // unmapped ignored
        for (i = 0; i < 32; i++) begin
            wr(8'h20 + 8'(i), (i % 4 == 0) ? 32'h100 : 32'h0);
            wr(8'h40 + 8'(i), (i % 4 == 0) ? 32'h100 : 32'h0);
        end
        rd_chk(8'h24, 32'h100); // coefficient kept
        // planar unity pass, one component per job
        cfg(11'h004, 11'h002, 11'h004, 11'h002, 11'h100, 11'h100); // component sizes
        run(32'h2);
        chk(mem_i.n_wr - w0, 32'h8); // planar bytes
        chk(mem_i.n_rd - r0, 32'h80); // four by four taps
        for (i = 0; i < 8; i++) outchk(16 * (i / 4) + i % 4, 16 * (i / 4) + i % 4); // passes
        chk({31'h0, irq}, 32'h1); // done raises irq
        rd_chk(`RSZ_OFF_INT_STATUS, 32'h1); // done flag
        wr(`RSZ_OFF_INT_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0); // cleared flag
        // packed, both byte orders, slow memory, irq masked
        wr(`RSZ_OFF_INT_MASK, 32'h0);
        slow <= 1'b1;
        cfg(11'h004, 11'h001, 11'h004, 11'h001, 11'h100, 11'h100); // four-tap sizing
        for (j = 0; j < 2; j++) begin
            run(j == 0 ? 32'h0 : 32'hC); // both orders
            chk(mem_i.n_wr - w0, 32'h8); // whole image one job
            for (i = 0; i < 8; i++) outchk(i, i); // chroma paths
            chk({31'h0, irq}, 32'h0); // masked source
            rd_chk(`RSZ_OFF_INT_STATUS, 32'h1); // done still flagged
            wr(`RSZ_OFF_INT_STATUS, 32'h1);
        end
        slow <= 1'b0;
        // quarter size, seven-tap bank with only tap zero of phase zero
        wr(8'h24, 32'h0);
        rd_chk(8'h24, 32'h0); // coefficient rewritten
        cfg(11'h00B, 11'h001, 11'h002, 11'h001, 11'h400, 11'h100); // seven-tap sizing
        run(32'h2); // planar job, bilinear bit left clear
        chk(mem_i.n_rd - r0, 32'h38); // seven taps
        for (i = 0; i < 2; i++) outchk(i, 4 * i); // step of 1024
        wr(`RSZ_OFF_INT_STATUS, 32'h1);
        // out-of-range steps are refused
        wr(`RSZ_OFF_INT_MASK, 32'h3);
        for (j = 0; j < 2; j++) begin
            cfg(11'h001, 11'h001, 11'h001, 11'h001, j == 0 ? 11'h03F : 11'h401, 11'h100);
            wr(`RSZ_OFF_CTRL, 32'h3);
            rd_chk(`RSZ_OFF_STATUS, 32'h0); // no job started
            rd_chk(`RSZ_OFF_INT_STATUS, 32'h2); // error flagged
            wr(`RSZ_OFF_INT_STATUS, 32'h3);
        end
        // lowest step accepted; second start while busy refused
        cfg(11'h001, 11'h001, 11'h001, 11'h001, 11'h040, 11'h040);
        wr(`RSZ_OFF_CTRL, 32'h3);
        run(32'h2);
        chk(mem_i.n_wr - w0, 32'h1); // single job
        outchk(0, 0); // step of 64
        rd_chk(`RSZ_OFF_INT_STATUS, 32'h3); // busy start refused
        chk({31'h0, irq}, 32'h1); // irq level
        rd_chk(`RSZ_OFF_CTRL, 32'h2); // format kept
        stop_test();
    end
endmodule : image_resizer_tb
`default_nettype wire

// ### resizer_defs.svh
// register offsets, field positions and limits of the resizer
// word-indexed offsets on the plain register port
`ifndef RESIZER_DEFS_SVH
`define RESIZER_DEFS_SVH

`define RSZ_ADDR_W 8
`define RSZ_OFF_CTRL 8'h00
`define RSZ_OFF_STATUS 8'h01
`define RSZ_OFF_INT_STATUS 8'h02
`define RSZ_OFF_INT_MASK 8'h03
`define RSZ_OFF_IN_SIZE 8'h04
`define RSZ_OFF_OUT_SIZE 8'h05
`define RSZ_OFF_STEP 8'h06
`define RSZ_OFF_PHASE 8'h07
`define RSZ_OFF_SRC_ADDR 8'h08
`define RSZ_OFF_DST_ADDR 8'h09
`define RSZ_OFF_PITCH 8'h0A
`define RSZ_PAGE_COEF_H 3'h1
`define RSZ_PAGE_COEF_V 3'h2

`define RSZ_CTRL_START 0
`define RSZ_CTRL_PLANAR 1
`define RSZ_CTRL_CFIRST 2
`define RSZ_CTRL_BILIN 3
`define RSZ_INT_DONE 0
`define RSZ_INT_ERR 1

`define RSZ_STEP_MIN 11'h040
`define RSZ_STEP_MAX 11'h400
`define RSZ_STEP_HALF 11'h200
`define RSZ_UNITY 10'h100
`define RSZ_PIX_MAX 20'h000FF

`endif

// ### resizer_mem_model.sv
// byte-wide system memory answering the resizer's master port
// ack lags the request one cycle, three when slow is set
`timescale 1ns/1ps
`default_nettype none

module resizer_mem_model
    import resizer_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // master port
    input wire mem_cmd_t mem_cmd,
    output mem_rsp_t mem_rsp,
    // pacing
    input wire logic slow
);
    logic [7:0] mem [0:4095];
    logic [1:0] wait_r = 2'h0;
    logic [7:0] last_r = 8'h00;
    int n_rd = 0;
    int n_wr = 0;
    logic ack;

    assign ack = mem_cmd.req && wait_r == (slow ? 2'h3 : 2'h1);
    // released data line shows the inverse of the last byte, never a stale copy
    assign mem_rsp = '{ack: ack, rdata: ack ? mem[mem_cmd.addr[11:0]] : ~last_r};

    always @(posedge clock) begin
        if (!resetn || !mem_cmd.req || ack) begin
            wait_r <= 2'h0;
        end else begin
            wait_r <= wait_r + 2'h1;
        end
        if (ack && mem_cmd.we) begin
            mem[mem_cmd.addr[11:0]] <= mem_cmd.wdata;
            n_wr <= n_wr + 1;
        end
        if (ack && !mem_cmd.we) begin
            last_r <= mem[mem_cmd.addr[11:0]];
            n_rd <= n_rd + 1;
        end
    end
endmodule : resizer_mem_model
`default_nettype wire

// ### resizer_pkg.sv
// types shared by the resizer: bus carriers, job states, block state
// constants live in resizer_defs.svh
`default_nettype none
package resizer_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [7:0] wdata;
    } mem_cmd_t;

    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
    } mem_rsp_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_FETCH = 2'b10,
        ST_WRITE = 2'b11
    } job_state_t;

    typedef struct packed {
        logic planar;
        logic cfirst;
        logic bilin;
    } mode_t;

    typedef struct packed {
        job_state_t st;
        mode_t mode;
        logic busy;
        logic [1:0] ists;
        logic [1:0] imask;
        logic [10:0] iw;
        logic [10:0] ih;
        logic [10:0] output_width;
        logic [10:0] output_height;
        logic [10:0] sth;
        logic [10:0] stv;
        logic [2:0] sph;
        logic [2:0] spv;
        logic [31:0] src;
        logic [31:0] dst;
        logic [15:0] sp;
        logic [15:0] dp;
        logic [31:0][9:0] ch;
        logic [31:0][9:0] cv;
        logic [11:0] ox;
        logic [10:0] oy;
        logic [2:0] vt;
        logic [2:0] ht;
        logic signed [21:0] hsum;
        logic signed [27:0] vacc;
        mem_cmd_t mem;
        logic [31:0] rdata;
    } core_t;

endpackage : resizer_pkg
`default_nettype wire
